// file: core/rbs_source_regs.sv
// Purpose: r-bus operand register, its sources and the mirrored stack slots
// Assumes: one clock, microinstruction fields valid every cycle
// Notes: all 16-bit words use [0:15] numbering, bit 0 the most significant
`timescale 1ns/10ps

// Behaviour
// - code 0100 loads pre-adder result
// - code 0000 loads program upper bound
// - code 1011 reads slot at mapped index
// - code 1010 reads mapped index plus one
// - code 1001 reads mapped index plus two
// - code 1000 reads mapped index plus three
// - code 0101 holds operand register
// - 1101 scratch zero, 1100 scratch one
// - 0001 loads fill count, rest zero
// - code 1110 loads upstream word bus
// - code 0110 loads offset word
// - 0111 loads offset or zero by bit4
// - code 0010 loads stack ceiling
// - eight slots, two groups, always equal
// - namer builds mapped index from state
// - scratch one shifts left, serial in/out
// - copy bits load with scratch one only
// - 0011 adds copy bits to rotation
// - code 1111 loads all zeros
// - three-bit fill count of occupied slots
module rbs_source_regs
  import rbs_pkg::*;
#(
  parameter int WORD_W = RBS_WORD_W
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // microinstruction fields
  input wire logic [3:0] hold_result_word_select,
  input wire logic [0:15] current_instr,
  // data sources from elsewhere in the processor
  input wire logic [0:15] preadd_word,
  input wire logic [0:15] upstream_word_bus,
  input wire logic [0:15] store_word,
  // register loads from the store decoder
  input wire logic load_upper_bound,
  input wire logic load_ceiling,
  input wire logic load_offset,
  input wire logic load_scratch_zero,
  input wire logic load_scratch_one,
  input wire logic shift_scratch_one,
  input wire logic scratch_one_serial_in,
  input wire logic slot_write,
  input wire logic [1:0] slot_write_index,
  // stack bookkeeping controls
  input wire logic fill_inc,
  input wire logic fill_dec,
  input wire logic fill_clear,
  input wire logic rotation_inc,
  input wire logic [1:0] sside_read_index,
  // results
  output logic [0:15] operand_word,
  output logic [0:15] sside_slot_word,
  output logic [2:0] stack_fill_count,
  output logic [1:0] slot_rotation,
  output logic [1:0] mapped_slot_index,
  output logic scratch_one_serial_out
);

  // state
  logic [0:15] operand_reg;
  logic [0:15] operand_next;
  logic [0:15] upper_bound_reg;
  logic [0:15] ceiling_reg;
  logic [0:15] offset_word_reg;
  logic [0:15] scratch_zero_reg;
  logic [0:15] scratch_one_reg;
  logic [1:0] scratch_one_copy_reg;
  logic [2:0] fill_reg;
  logic [2:0] fill_next;
  logic [1:0] rotation_reg;
  logic [1:0] mapped_reg;
  logic [0:15] sside_reg;
  logic [0:15] slot_rside [4];
  logic [0:15] slot_sside [4];

  // namer: rotation, plus copy bits for memory slot fetch
  wire logic is_mem_fetch = (hold_result_word_select == RBS_SEL_MEM_SLOT);
  wire logic [1:0] copy_add = is_mem_fetch ? scratch_one_copy_reg : 2'h0;
  wire logic [1:0] mapped_slot = rotation_reg + copy_add;

  // position of the requested element above the mapped index
  wire logic [1:0] slot_offset =
    (hold_result_word_select == RBS_SEL_SECOND) ? RBS_OFS_SECOND :
    (hold_result_word_select == RBS_SEL_THIRD) ? RBS_OFS_THIRD :
    (hold_result_word_select == RBS_SEL_FOURTH) ? RBS_OFS_FOURTH : RBS_OFS_TOP;
  // no check against fill count; a short stack just reads the slot
  wire logic [1:0] read_slot = mapped_slot + slot_offset;
  wire logic [0:15] slot_word = slot_rside[read_slot];

  // fill count placed in bits 0 to 2, the rest zero
  wire logic [0:15] fill_word = {fill_reg, 13'h0000};
  wire logic [0:15] cond_offset =
    current_instr[RBS_INDEX_BIT] ? offset_word_reg : 16'h0000;

  // operand source selection
  always_comb begin
    case (hold_result_word_select)
      RBS_SEL_UPPER_BOUND: operand_next = upper_bound_reg;
      RBS_SEL_FILL_COUNT: operand_next = fill_word;
      RBS_SEL_CEILING: operand_next = ceiling_reg;
      RBS_SEL_MEM_SLOT: operand_next = slot_word;
      RBS_SEL_PREADD: operand_next = preadd_word;
      RBS_SEL_HOLD: operand_next = operand_reg;
      RBS_SEL_OFFSET: operand_next = offset_word_reg;
      RBS_SEL_COND_OFFSET: operand_next = cond_offset;
      RBS_SEL_FOURTH: operand_next = slot_word;
      RBS_SEL_THIRD: operand_next = slot_word;
      RBS_SEL_SECOND: operand_next = slot_word;
      RBS_SEL_TOP: operand_next = slot_word;
      RBS_SEL_SCRATCH_ONE: operand_next = scratch_one_reg;
      RBS_SEL_SCRATCH_ZERO: operand_next = scratch_zero_reg;
      RBS_SEL_UPSTREAM: operand_next = upstream_word_bus;
      default: operand_next = 16'h0000;
    endcase
  end

  // fill count: clear wins; increment and decrement together leave the count unchanged
  always_comb begin
    if (fill_clear) begin
      fill_next = RBS_FILL_RST;
    end else if (fill_inc && !fill_dec) begin
      fill_next = fill_reg + 3'h1;
    end else if (fill_dec && !fill_inc) begin
      fill_next = fill_reg - 3'h1;
    end else begin
      fill_next = fill_reg;
    end
  end

  // operand register, once per microcycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      operand_reg <= RBS_WORD_RST;
    end else begin
      operand_reg <= operand_next;
    end
  end

  // stack bookkeeping and registered namer output
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fill_reg <= RBS_FILL_RST;
      rotation_reg <= RBS_SLOT_RST;
      mapped_reg <= RBS_SLOT_RST;
    end else begin
      fill_reg <= fill_next;
      rotation_reg <= rotation_reg + {1'b0, rotation_inc};
      mapped_reg <= mapped_slot;
    end
  end

  // plain source registers loaded from the store word
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      upper_bound_reg <= RBS_WORD_RST;
      ceiling_reg <= RBS_WORD_RST;
      offset_word_reg <= RBS_WORD_RST;
      scratch_zero_reg <= RBS_WORD_RST;
    end else begin
      if (load_upper_bound) upper_bound_reg <= store_word;
      if (load_ceiling) ceiling_reg <= store_word;
      if (load_offset) offset_word_reg <= store_word;
      if (load_scratch_zero) scratch_zero_reg <= store_word;
    end
  end

  // scratch one: load wins over shift; copy bits only follow a load
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      scratch_one_reg <= RBS_WORD_RST;
      scratch_one_copy_reg <= RBS_SLOT_RST;
    end else if (load_scratch_one) begin
      scratch_one_reg <= store_word;
      scratch_one_copy_reg <= store_word[RBS_COPY_HI:RBS_COPY_LO];
    end else if (shift_scratch_one) begin
      scratch_one_reg <= {scratch_one_reg[1:15], scratch_one_serial_in};
    end
  end

  // mirrored slot groups, one write updates both copies
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        slot_rside[i] <= RBS_WORD_RST;
        slot_sside[i] <= RBS_WORD_RST;
      end
    end else if (slot_write) begin
      slot_rside[slot_write_index] <= store_word;
      slot_sside[slot_write_index] <= store_word;
    end
  end

  // s-side group read port
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sside_reg <= RBS_WORD_RST;
    end else begin
      sside_reg <= slot_sside[sside_read_index];
    end
  end

  // outputs straight from flip-flops
  assign operand_word = operand_reg;
  assign sside_slot_word = sside_reg;
  assign stack_fill_count = fill_reg;
  assign slot_rotation = rotation_reg;
  assign mapped_slot_index = mapped_reg;
  assign scratch_one_serial_out = scratch_one_reg[RBS_SERIAL_OUT_BIT];

endmodule // rbs_source_regs

// file: pkg/rbs_pkg.sv
// Purpose: shared constants for the r-bus source and stack register block
// Assumes: words numbered 0 (msb) to 15 (lsb), as the processor numbers them
// Notes: select codes are the 4-bit r-bus field of the microinstruction
package rbs_pkg;
  localparam int RBS_WORD_W = 16;
  localparam int RBS_SEL_W = 4;
  localparam int RBS_FILL_W = 3;
  localparam int RBS_SLOT_W = 2;
  // r-bus select codes
  localparam logic [3:0] RBS_SEL_UPPER_BOUND = 4'h0;
  localparam logic [3:0] RBS_SEL_FILL_COUNT = 4'h1;
  localparam logic [3:0] RBS_SEL_CEILING = 4'h2;
  localparam logic [3:0] RBS_SEL_MEM_SLOT = 4'h3;
  localparam logic [3:0] RBS_SEL_PREADD = 4'h4;
  localparam logic [3:0] RBS_SEL_HOLD = 4'h5;
  localparam logic [3:0] RBS_SEL_OFFSET = 4'h6;
  localparam logic [3:0] RBS_SEL_COND_OFFSET = 4'h7;
  localparam logic [3:0] RBS_SEL_FOURTH = 4'h8;
  localparam logic [3:0] RBS_SEL_THIRD = 4'h9;
  localparam logic [3:0] RBS_SEL_SECOND = 4'ha;
  localparam logic [3:0] RBS_SEL_TOP = 4'hb;
  localparam logic [3:0] RBS_SEL_SCRATCH_ONE = 4'hc;
  localparam logic [3:0] RBS_SEL_SCRATCH_ZERO = 4'hd;
  localparam logic [3:0] RBS_SEL_UPSTREAM = 4'he;
  localparam logic [3:0] RBS_SEL_ZERO = 4'hf;
  // field positions
  localparam int RBS_INDEX_BIT = 4;
  localparam int RBS_COPY_HI = 14;
  localparam int RBS_COPY_LO = 15;
  localparam int RBS_SERIAL_OUT_BIT = 0;
  // slot offsets above the mapped index
  localparam logic [1:0] RBS_OFS_TOP = 2'h0;
  localparam logic [1:0] RBS_OFS_SECOND = 2'h1;
  localparam logic [1:0] RBS_OFS_THIRD = 2'h2;
  localparam logic [1:0] RBS_OFS_FOURTH = 2'h3;
  // values after reset
  localparam logic [0:15] RBS_WORD_RST = 16'h0000;
  localparam logic [2:0] RBS_FILL_RST = 3'h0;
  localparam logic [1:0] RBS_SLOT_RST = 2'h0;
endpackage

// file: test/rbs_seq_model.sv
// Purpose: sequencer model issuing r-bus select codes
// Assumes: fill count seen as the block reports it
// Notes: a stack read short of data is turned into a hold
`timescale 1ns/10ps
module rbs_seq_model
  import rbs_pkg::*;
(
  // requested code and stack state
  input wire logic [3:0] want,
  input wire logic [2:0] fill,
  // issued field
  output logic [3:0] hold_result_word_select
);
  // slots a stack read needs: top 1, second 2, third 3, fourth 4
  wire logic rd = want[3] & ~want[2];
  wire logic [2:0] need = 3'h4 - {1'b0, want[1:0]};
  wire logic ok = (want[1:0] == 2'h0) ? (fill == 3'h4) : (fill >= need);
  assign hold_result_word_select = (rd && !ok) ? RBS_SEL_HOLD : want;
endmodule // rbs_seq_model

// file: test/rbs_source_regs_monitor.sv
// Purpose: port checker for the r-bus source block
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every instance of the block
`timescale 1ns/10ps
module rbs_source_regs_monitor
  import rbs_pkg::*;
(
  // clock, reset, fields and controls
  input wire logic core_clk, rst_n, load_scratch_one, fill_clear, rotation_inc,
  input wire logic [3:0] hold_result_word_select,
  input wire logic [0:15] current_instr, preadd_word, store_word,
  // results
  input wire logic [0:15] operand_word,
  input wire logic [2:0] stack_fill_count,
  input wire logic [1:0] slot_rotation
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // scratch one loaded, then selected in the next cycle
  sequence s_load_read;
    load_scratch_one ##1 hold_result_word_select == RBS_SEL_SCRATCH_ONE;
  endsequence
  AST_PREADD: assert property (hold_result_word_select == RBS_SEL_PREADD |=>
    operand_word == $past(preadd_word)) else $error("preadd");
  AST_HOLD: assert property (hold_result_word_select == RBS_SEL_HOLD |=>
    $stable(operand_word)) else $error("hold");
  AST_ZERO: assert property (hold_result_word_select == RBS_SEL_ZERO |=>
    operand_word == 16'h0000) else $error("zero");
  AST_FILL: assert property (hold_result_word_select == RBS_SEL_FILL_COUNT |=>
    operand_word == {$past(stack_fill_count), 13'h0000}) else $error("fill");
  AST_COND: assert property (hold_result_word_select == RBS_SEL_COND_OFFSET &&
    !current_instr[RBS_INDEX_BIT] |=> operand_word == 16'h0000) else $error("cond");
  AST_SCR1: assert property (s_load_read |=>
    operand_word == $past(store_word, 2)) else $error("scratch one");
  AST_CLR: assert property (fill_clear |=> stack_fill_count == 3'h0)
    else $error("clear");
  AST_ROT: assert property (rotation_inc |=>
    slot_rotation == $past(slot_rotation) + 2'h1) else $error("rotation");
endmodule // rbs_source_regs_monitor
bind rbs_source_regs rbs_source_regs_monitor u_mon (.core_clk, .rst_n, .load_scratch_one,
  .fill_clear, .rotation_inc, .hold_result_word_select, .current_instr, .preadd_word, .store_word,
  .operand_word, .stack_fill_count, .slot_rotation);

// file: test/test_rbs_source_regs.sv
// Purpose: self-checking bench for the r-bus source block
// Assumes: select codes pass through the sequencer model
// Notes: a shadow model predicts every operand word
`timescale 1ns/10ps
module test_rbs_source_regs;
  import rbs_pkg::*;
  // stimulus
  logic core_clk = 1'b0, rst_n = 1'b0;
  logic [3:0] want = 4'h0;
  logic [0:15] ci = 16'h0000, pa = 16'h0000, ub = 16'h0000, sw = 16'h0000;
  logic [11:0] c = 12'h000;
  logic [1:0] wi = 2'h0, ri = 2'h0;
  // results and shadow state
  wire logic [3:0] sel;
  wire logic [0:15] ow, so;
  wire logic [2:0] fc;
  wire logic [1:0] ro, mi;
  wire logic sout;
  logic [0:15] sl [4];
  logic [0:15] pl, zc, ofs, s0, s1, ex;
  logic [2:0] fill;
  logic [1:0] rot, cp;
  integer seed = 32'h1897, mismatches = 0, n_compared = 0;
  always #2 core_clk = ~core_clk;
  rbs_seq_model u_seq (.want(want), .fill(fc), .hold_result_word_select(sel));
  rbs_source_regs DUT (.core_clk(core_clk), .rst_n(rst_n), .hold_result_word_select(sel),
    .current_instr(ci), .preadd_word(pa), .upstream_word_bus(ub), .store_word(sw),
    .load_upper_bound(c[0]), .load_ceiling(c[1]), .load_offset(c[2]),
    .load_scratch_zero(c[3]), .load_scratch_one(c[4]), .shift_scratch_one(c[5]),
    .scratch_one_serial_in(c[6]), .slot_write(c[7]), .slot_write_index(wi),
    .fill_inc(c[8]), .fill_dec(c[9]), .fill_clear(c[10]), .rotation_inc(c[11]),
    .sside_read_index(ri), .operand_word(ow), .sside_slot_word(so),
    .stack_fill_count(fc), .slot_rotation(ro), .mapped_slot_index(mi),
    .scratch_one_serial_out(sout));
  // expected operand word for an issued code
  function automatic logic [0:15] f(logic [3:0] s);
    case (s)
      4'h0: f = pl;
      4'h1: f = {fill, 13'h0000};
      4'h2: f = zc;
      4'h3: f = sl[rot + cp];
      4'h4: f = pa;
      4'h5: f = ex;
      4'h6: f = ofs;
      4'h7: f = ci[RBS_INDEX_BIT] ? ofs : 16'h0000;
      4'hc: f = s1;
      4'hd: f = s0;
      4'he: f = ub;
      4'hf: f = 16'h0000;
      default: f = sl[rot + 2'h3 - s[1:0]];
    endcase
  endfunction
  // compare and count
  task automatic chk(string n, logic [0:15] s, logic [0:15] e);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // one select code, checked after the edge that takes it
  task automatic issue(logic [3:0] w);
    @(posedge core_clk);
    want <= w;
    pa <= $random(seed);
    ub <= $random(seed);
    ci <= $random(seed);
    @(posedge core_clk);
    #1;
    ex = f(sel);
    chk("operand", ow, ex);
    chk("mapped", mi, {14'h0000, rot + ((sel == RBS_SEL_MEM_SLOT) ? cp : 2'h0)});
  endtask
  // one cycle of register controls, then shadow update
  task automatic pulse(logic [11:0] v, logic [1:0] i);
    @(posedge core_clk);
    c <= v;
    wi <= i;
    sw <= $random(seed);
    @(posedge core_clk);
    c <= 12'h000;
    #1;
    if (v[0]) pl = sw;
    if (v[1]) zc = sw;
    if (v[2]) ofs = sw;
    if (v[3]) s0 = sw;
    if (v[4]) {s1, cp} = {sw, sw[14:15]};
    else if (v[5]) s1 = {s1[1:15], v[6]};
    if (v[7]) sl[i] = sw;
    if (v[11]) rot = rot + 2'h1;
    fill = v[10] ? 3'h0 : fill + v[8] - v[9];
    chk("fill", fc, fill);
    chk("rotation", ro, rot);
  endtask
  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // watchdog
  initial begin
    #8000;
    mismatches++;
    end_of_test;
  end
  initial begin
    {pl, zc, ofs, s0, s1, ex, fill, rot, cp} = '0;
    foreach (sl[k]) sl[k] = 16'h0000;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    chk("reset", ow, RBS_WORD_RST);
    for (int k = 0; k < 5; k++) pulse(12'h001 << k, 2'h0);
    for (int k = 0; k < 4; k++) begin
      pulse(12'h180, k[1:0]);
      @(posedge core_clk);
      ri <= k[1:0];
      @(posedge core_clk);
      #1;
      chk("sside", so, sl[k]);
    end
    for (int r = 0; r < 4; r++) begin
      for (int s = 0; s < 16; s++) issue(s[3:0]);
      pulse(12'h810, 2'h0);
    end
    $display("test sources done");
    for (int k = 0; k < 4; k++) begin
      pulse(12'h200, 2'h0);
      for (int s = 8; s < 12; s++) issue(s[3:0]);
    end
    pulse(12'h500, 2'h0);
    issue(RBS_SEL_FILL_COUNT);
    $display("test short stack done");
    @(posedge core_clk);
    want <= RBS_SEL_SCRATCH_ONE;
    pulse(12'h010, 2'h0);
    for (int k = 0; k < 6; k++) begin
      pulse(k[0] ? 12'h060 : 12'h020, 2'h0);
      chk("serial", sout, s1[0]);
    end
    issue(RBS_SEL_SCRATCH_ONE);
    issue(RBS_SEL_MEM_SLOT);
    $display("test shift done");
    end_of_test;
  end
endmodule // test_rbs_source_regs
